// ===== design/amp_status_phase_ss_regs.sv
// APB register bank for pin inversion, identifier, power and mute status, ramp phase and spread-spectrum enables.
//
// Operation
// - Bits 2 to 0 of the flip register invert the level driven on pins 0 to 2.
// - The identifier register reads a fixed code that no write can change.
// - The power register reports deep sleep 0, sleep 1, high impedance 2 and play 3.
// - Mute status bit 1 is high exactly while the right channel is auto-muted.
// - Mute status bit 0 is high exactly while the left channel is auto-muted.
// - Phase bits 3 to 2 pick ramp phase 0 to 3, each step 45 degrees apart.
// - Phase bit 1 takes synchronisation from a pin when low and internally when high.
// - Phase bit 0 enables ramp phase synchronisation and resets to zero.
// - In manual mode spread bit 5 picks the halved PLL clock as source.
// - Spread bit 4 puts the spread-spectrum controller into manual mode.
// - A pin set to show the user value drives that value after inversion.
// - A pin may be routed to show the left channel mute flag.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module amp_status_phase_ss_regs #(
  // Identifier value is arbitrary.
  parameter logic [7:0] SILICON_ID = 8'h5a
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [11:0]                paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [7:0]                 power_state_code,
  input  wire logic                       right_silenced_flag,
  input  wire logic                       left_silenced_flag,
  input  wire amp_regs_pkg::pin_sel_vec_t pin_select,
  input  wire logic [2:0]                 pin_user_value,
  output logic [2:0]                      pin_drive,
  input  wire logic                       sync_pin,
  input  wire logic                       internal_sync_pulse,
  output amp_regs_pkg::phase_cfg_t        phase_cfg,
  output logic [7:0]                      ramp_phase_deg,
  output logic                            ramp_sync_pulse,
  output amp_regs_pkg::ss_cfg_t           ss_cfg
);
  logic [9:0]  word_idx;
  logic        addr_hit;
  logic        setup_rd;
  logic        wr_en;
  logic [7:0]  wdata_byte;
  logic [7:0]  rd_byte;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [7:0]  flip_r;
  logic [7:0]  flip_nxt;
  logic [7:0]  phase_r;
  logic [7:0]  phase_nxt;
  logic [7:0]  ss_r;
  logic [7:0]  ss_nxt;
  logic [7:0]  power_r;
  logic [1:0]  mute_r;
  logic [1:0]  applied_phase_r;
  logic [1:0]  applied_phase_nxt;
  logic        sync_pin_s;
  logic        sync_prev_r;
  logic        sync_event;
  logic        sync_pulse_r;

  // ****************************************
  // APB decode and register storage
  // ****************************************
  // Bus decode; every access completes without wait states.
  assign word_idx   = paddr[11:2];
  assign wdata_byte = pwdata[7:0];
  assign addr_hit   = (word_idx == amp_regs_pkg::IDX_FLIP)  || (word_idx == amp_regs_pkg::IDX_ID)
                   || (word_idx == amp_regs_pkg::IDX_POWER) || (word_idx == amp_regs_pkg::IDX_MUTE)
                   || (word_idx == amp_regs_pkg::IDX_PHASE) || (word_idx == amp_regs_pkg::IDX_SS);
  assign setup_rd   = psel && !penable && !pwrite;
  assign wr_en      = psel && penable && pwrite && pstrb[0] && addr_hit;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !addr_hit;

  // Read multiplexer; bits above each 8-bit register read as zero.
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (word_idx)
      amp_regs_pkg::IDX_FLIP:  rd_byte = flip_r;
      amp_regs_pkg::IDX_ID:    rd_byte = SILICON_ID;
      amp_regs_pkg::IDX_POWER: rd_byte = power_r;
      amp_regs_pkg::IDX_MUTE:  rd_byte = {6'h00, mute_r};
      amp_regs_pkg::IDX_PHASE: rd_byte = phase_r;
      amp_regs_pkg::IDX_SS:    rd_byte = ss_r;
      default:                 rd_byte = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle so it stands through the access phase.
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (setup_rd)
      prdata_nxt = {24'h000000, rd_byte};
  end

  // Writable registers take the low byte lane; read-only words ignore writes.
  always_comb
  begin
    flip_nxt  = flip_r;
    phase_nxt = phase_r;
    ss_nxt    = ss_r;
    if (wr_en)
    begin
      unique case (word_idx)
        amp_regs_pkg::IDX_FLIP:  flip_nxt = wdata_byte;
        amp_regs_pkg::IDX_PHASE: phase_nxt = wdata_byte;
        amp_regs_pkg::IDX_SS:    ss_nxt = wdata_byte;
        default:                 ss_nxt = ss_r;
      endcase
    end
  end

  // Bus-side registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      flip_r   <= amp_regs_pkg::RST_FLIP;
      phase_r  <= amp_regs_pkg::RST_PHASE;
      ss_r     <= amp_regs_pkg::RST_SS;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      flip_r   <= flip_nxt;
      phase_r  <= phase_nxt;
      ss_r     <= ss_nxt;
    end
  end

  assign prdata = prdata_r;

  // ****************************************
  // Status and configuration
  // ****************************************
  // Status sampled each cycle from the core.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_r <= amp_regs_pkg::RST_POWER;
      mute_r  <= amp_regs_pkg::RST_MUTE;
    end
    else
    begin
      power_r                             <= power_state_code;
      mute_r[amp_regs_pkg::MUTE_RIGHT_BIT] <= right_silenced_flag;
      mute_r[amp_regs_pkg::MUTE_LEFT_BIT]  <= left_silenced_flag;
    end
  end

  // Configuration decode for the ramp controller.
  assign phase_cfg.phase_sel     = phase_r[amp_regs_pkg::PH_SEL_LSB +: 2];
  assign phase_cfg.sync_internal = phase_r[amp_regs_pkg::PH_SYNC_SEL_BIT];
  assign phase_cfg.sync_en       = phase_r[amp_regs_pkg::PH_SYNC_EN_BIT];
  assign ss_cfg.manual    = ss_r[amp_regs_pkg::SS_MANUAL_BIT];
  assign ss_cfg.div2_src  = ss_r[amp_regs_pkg::SS_DIV2_BIT] & ss_r[amp_regs_pkg::SS_MANUAL_BIT];
  assign ss_cfg.random_en = ss_r[amp_regs_pkg::SS_RDM_BIT];
  assign ss_cfg.tri_en    = ss_r[amp_regs_pkg::SS_TRI_BIT];

  // ****************************************
  // Ramp phase and synchronisation
  // ****************************************
  // The ramp phase is taken up only outside play, so a change made in play waits.
  always_comb
  begin
    applied_phase_nxt = applied_phase_r;
    if (power_r != amp_regs_pkg::PWR_PLAY)
      applied_phase_nxt = phase_cfg.phase_sel;
  end

  assign ramp_phase_deg = 8'(applied_phase_r * amp_regs_pkg::PHASE_STEP_DEG);

  pin_sync2 u_sync_pin (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sync_pin),
    .sync_out (sync_pin_s)
  );

  assign sync_event = phase_cfg.sync_en
                   && (phase_cfg.sync_internal ? internal_sync_pulse : (sync_pin_s && !sync_prev_r));

  // Phase hold, pin edge history and the sync pulse register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied_phase_r <= 2'h0;
      sync_prev_r     <= 1'b0;
      sync_pulse_r    <= 1'b0;
    end
    else
    begin
      applied_phase_r <= applied_phase_nxt;
      sync_prev_r     <= sync_pin_s;
      sync_pulse_r    <= sync_event;
    end
  end

  assign ramp_sync_pulse = sync_pulse_r;

  // ****************************************
  // Pin drive
  // ****************************************
  // Pin sources and inversion, registered before they leave the block.
  pin_drive_mux u_pin_mux (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin_select  (pin_select),
    .user_value  (pin_user_value),
    .flip        (flip_r[2:0]),
    .left_muted  (mute_r[amp_regs_pkg::MUTE_LEFT_BIT]),
    .right_muted (mute_r[amp_regs_pkg::MUTE_RIGHT_BIT]),
    .pin_drive   (pin_drive)
  );

  // ****************************************
  // Checks on the register behaviour.
  // ****************************************
  a_id_read_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && word_idx == amp_regs_pkg::IDX_ID) |=> (prdata == {24'h000000, SILICON_ID}))
    else $error("Identifier read is not the fixed code.");

  a_power_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && word_idx == amp_regs_pkg::IDX_POWER) |=> (prdata[7:0] == $past(power_state_code, 2)))
    else $error("Power report does not follow the core state.");

  a_right_mute_bit: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (mute_r[amp_regs_pkg::MUTE_RIGHT_BIT] == $past(right_silenced_flag)))
    else $error("Right mute status bit is wrong.");

  a_left_mute_bit: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (mute_r[amp_regs_pkg::MUTE_LEFT_BIT] == $past(left_silenced_flag)))
    else $error("Left mute status bit is wrong.");

  a_phase_deg_step: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && word_idx == amp_regs_pkg::IDX_PHASE && power_r != amp_regs_pkg::PWR_PLAY
     && power_state_code != amp_regs_pkg::PWR_PLAY)
    |=> ##1 (ramp_phase_deg == 8'(phase_cfg.phase_sel * amp_regs_pkg::PHASE_STEP_DEG)))
    else $error("Ramp phase offset is not the selected step.");

  a_phase_hold_play: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(power_r) == amp_regs_pkg::PWR_PLAY) |-> $stable(applied_phase_r))
    else $error("Ramp phase changed during play.");

  a_sync_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_sync_pulse |-> $past(phase_cfg.sync_en))
    else $error("Sync pulse while synchronisation is disabled.");

  a_internal_sync_src: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_cfg.sync_en && phase_cfg.sync_internal && internal_sync_pulse) |=> ramp_sync_pulse)
    else $error("Internal sync pulse was not passed on.");

  a_div2_manual_only: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && word_idx == amp_regs_pkg::IDX_SS)
    |=> (ss_cfg.div2_src == ($past(wdata_byte[amp_regs_pkg::SS_DIV2_BIT])
                             && $past(wdata_byte[amp_regs_pkg::SS_MANUAL_BIT]))))
    else $error("Halved source selected outside manual mode.");

  a_flip_write_store: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && word_idx == amp_regs_pkg::IDX_FLIP) |=> (flip_r == $past(wdata_byte)))
    else $error("Flip register did not take the written byte.");

  a_pin_sync_src: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_cfg.sync_en && !phase_cfg.sync_internal && sync_pin_s && !sync_prev_r) |=> ramp_sync_pulse)
    else $error("Pin sync edge was not passed on.");

  a_ro_write_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && word_idx == amp_regs_pkg::IDX_ID) |-> !pslverr)
    else $error("Write to the identifier raised an error.");

  a_ss_write_enables: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && word_idx == amp_regs_pkg::IDX_SS)
    |=> (ss_cfg.random_en == $past(wdata_byte[1]) && ss_cfg.tri_en == $past(wdata_byte[0])
         && ss_cfg.manual == $past(wdata_byte[4])))
    else $error("Spread-spectrum enables do not follow the write.");
endmodule
`default_nettype wire

// ===== design/amp_regs_pkg.sv
// Register map, field layout and shared types of the amplifier status, phase and spread-spectrum bank.
package amp_regs_pkg;
  // Register indices; the APB byte address is four times the index.
  localparam logic [9:0] IDX_FLIP  = 10'h066;
  localparam logic [9:0] IDX_ID    = 10'h067;
  localparam logic [9:0] IDX_POWER = 10'h068;
  localparam logic [9:0] IDX_MUTE  = 10'h069;
  localparam logic [9:0] IDX_PHASE = 10'h06a;
  localparam logic [9:0] IDX_SS    = 10'h06b;

  // Reset values of the stored and sampled registers.
  localparam logic [7:0] RST_FLIP  = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [1:0] RST_MUTE  = 2'h0;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_SS    = 8'h00;

  // Field positions inside the registers.
  localparam int PH_SEL_LSB      = 2;
  localparam int PH_SYNC_SEL_BIT = 1;
  localparam int PH_SYNC_EN_BIT  = 0;
  localparam int SS_DIV2_BIT     = 5;
  localparam int SS_MANUAL_BIT   = 4;
  localparam int SS_RDM_BIT      = 1;
  localparam int SS_TRI_BIT      = 0;
  localparam int MUTE_RIGHT_BIT  = 1;
  localparam int MUTE_LEFT_BIT   = 0;

  // Phase distance between adjacent ramp phases, in degrees.
  localparam logic [7:0] PHASE_STEP_DEG = 8'h2d;

  // Pin output selection codes handled by this bank.
  localparam logic [3:0] SEL_OFF        = 4'h0;
  localparam logic [3:0] SEL_USER       = 4'h2;
  localparam logic [3:0] SEL_MUTE_BOTH  = 4'h3;
  localparam logic [3:0] SEL_MUTE_LEFT  = 4'h4;
  localparam logic [3:0] SEL_MUTE_RIGHT = 4'h5;

  // Power state codes as reported to software.
  typedef enum logic [7:0]
  {
    PWR_DEEP_SLEEP = 8'h00,
    PWR_SLEEP      = 8'h01,
    PWR_HIZ        = 8'h02,
    PWR_PLAY       = 8'h03
  } power_state_t;

  typedef logic [2:0][3:0] pin_sel_vec_t;

  typedef struct packed
  {
    logic [1:0] phase_sel;
    logic       sync_internal;
    logic       sync_en;
  } phase_cfg_t;

  typedef struct packed
  {
    logic manual;
    logic div2_src;
    logic random_en;
    logic tri_en;
  } ss_cfg_t;
endpackage

// ===== design/pin_sync2.sv
// Two-flop synchroniser for one level arriving from a pin.
`timescale 1ns/1ns
`default_nettype none
module pin_sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  logic sync_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// ===== design/pin_drive_mux.sv
// Per-pin output source selection and inversion for the three general-purpose pins.
`timescale 1ns/1ns
`default_nettype none
module pin_drive_mux (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire amp_regs_pkg::pin_sel_vec_t pin_select,
  input  wire logic [2:0]                 user_value,
  input  wire logic [2:0]                 flip,
  input  wire logic                       left_muted,
  input  wire logic                       right_muted,
  output logic [2:0]                      pin_drive
);
  logic [2:0] drive_nxt;
  logic [2:0] drive_r;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin
      logic raw_val;

      // Pick the source named by the pin's selection code; other codes give a low source that the flip bit still inverts.
      always_comb
      begin
        raw_val = 1'b0;
        unique case (pin_select[g])
          amp_regs_pkg::SEL_USER:       raw_val = user_value[g];
          amp_regs_pkg::SEL_MUTE_BOTH:  raw_val = left_muted & right_muted;
          amp_regs_pkg::SEL_MUTE_LEFT:  raw_val = left_muted;
          amp_regs_pkg::SEL_MUTE_RIGHT: raw_val = right_muted;
          default:                      raw_val = 1'b0;
        endcase
        drive_nxt[g] = raw_val ^ flip[g];
      end

      a_user_flip_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_select[g] == amp_regs_pkg::SEL_USER) |=> (drive_r[g] == $past(user_value[g] ^ flip[g])))
        else $error("Pin does not show the inverted user value.");

      a_left_mute_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_select[g] == amp_regs_pkg::SEL_MUTE_LEFT) |=> (drive_r[g] == $past(left_muted ^ flip[g])))
        else $error("Pin does not show the left mute flag.");
    end
  endgenerate

  // Pin levels leave from flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive_r <= 3'h0;
    else
      drive_r <= drive_nxt;
  end

  assign pin_drive = drive_r;
endmodule
`default_nettype wire

// ===== verif/test_amp_status_phase_ss_regs.sv
// Self-checking bench for the amplifier status, phase and spread-spectrum register bank.
`timescale 1ns/1ns
`default_nettype none
module test_amp_status_phase_ss_regs;
  // Identifier value is arbitrary.
  localparam logic [7:0] ID_VAL = 8'h3c;

  logic                       pclk;
  logic                       presetn;
  logic [11:0]                paddr;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [31:0]                pwdata;
  logic [3:0]                 pstrb;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [7:0]                 power_state_code;
  logic                       right_silenced_flag;
  logic                       left_silenced_flag;
  amp_regs_pkg::pin_sel_vec_t pin_select;
  logic [2:0]                 pin_user_value;
  logic [2:0]                 pin_drive;
  logic                       sync_pin;
  logic                       internal_sync_pulse;
  amp_regs_pkg::phase_cfg_t   phase_cfg;
  logic [7:0]                 ramp_phase_deg;
  logic                       ramp_sync_pulse;
  amp_regs_pkg::ss_cfg_t      ss_cfg;
  int                         n_fail;
  int                         total_checks;

  amp_status_phase_ss_regs #(.SILICON_ID(ID_VAL)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_state_code(power_state_code), .right_silenced_flag(right_silenced_flag),
    .left_silenced_flag(left_silenced_flag), .pin_select(pin_select), .pin_user_value(pin_user_value),
    .pin_drive(pin_drive), .sync_pin(sync_pin), .internal_sync_pulse(internal_sync_pulse),
    .phase_cfg(phase_cfg), .ramp_phase_deg(ramp_phase_deg), .ramp_sync_pulse(ramp_sync_pulse),
    .ss_cfg(ss_cfg)
  );

  // ****************************************
  // Clock, verdict and watchdog
  // ****************************************
  // The clock toggles every 25 ns, a period of 50 ns.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("FAIL watchdog expected end of tests seen hang");
    tally_and_finish();
  end

  // ****************************************
  // Bus and comparison tasks
  // ****************************************
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  // One APB transfer: setup cycle, then access until pready is seen high.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, input logic [3:0] strb,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    check("pready wait states", 32'(n), 32'h0);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, 4'hf, r, e);
  endtask

  // Reads a register and checks data and a clean response.
  task automatic rdc(input string what, input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, 4'h0, r, e);
    check(what, r, {24'h0, exp});
    check({what, " error"}, {31'h0, e}, 32'h0);
  endtask

  // Counts mid-cycle samples with the sync pulse high, then returns on a rising edge.
  task automatic count_sync(input int n, output int cnt);
    cnt = 0;
    repeat (n)
    begin
      @(negedge pclk);
      if (ramp_sync_pulse === 1'b1)
        cnt++;
    end
    @(posedge pclk);
  endtask

  // Level expected on the pins for one source code on all three.
  function automatic logic [2:0] pin_exp(input logic [3:0] c, input logic [2:0] u, input logic l, input logic r,
                                         input logic [2:0] f);
    logic [2:0] s;
    case (c)
      4'h2: s = u;
      4'h3: s = {3{l & r}};
      4'h4: s = {3{l}};
      4'h5: s = {3{r}};
      default: s = 3'h0;
    endcase
    return s ^ f;
  endfunction

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  d;
    logic [2:0]  flips[3];
    logic [9:0]  rw_idx[3];
    logic [7:0]  ss_vals[7];
    int          cnt;
    flips = '{3'h0, 3'h6, 3'h3};
    rw_idx = '{amp_regs_pkg::IDX_FLIP, amp_regs_pkg::IDX_PHASE, amp_regs_pkg::IDX_SS};
    ss_vals = '{8'h00, 8'h20, 8'h30, 8'h10, 8'h02, 8'h01, 8'h23};
    n_fail = 0;
    total_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {power_state_code, right_silenced_flag, left_silenced_flag, pin_user_value} = '0;
    pin_select = '0;
    sync_pin = 1'b0;
    internal_sync_pulse = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc("flip reset", amp_regs_pkg::IDX_FLIP, 8'h00);
    rdc("identifier", amp_regs_pkg::IDX_ID, ID_VAL);
    rdc("mute reset", amp_regs_pkg::IDX_MUTE, 8'h00);
    rdc("phase reset", amp_regs_pkg::IDX_PHASE, 8'h00);
    rdc("spread reset", amp_regs_pkg::IDX_SS, 8'h00);
    wr(amp_regs_pkg::IDX_ID, ~ID_VAL);
    rdc("identifier after write", amp_regs_pkg::IDX_ID, ID_VAL);
    $display("test reset values done");
    foreach (rw_idx[i])
    begin
      wr(rw_idx[i], 8'ha5);
      rdc("rw a5", rw_idx[i], 8'ha5);
      wr(rw_idx[i], 8'h5a);
      rdc("rw 5a", rw_idx[i], 8'h5a);
    end
    apb(1'b1, amp_regs_pkg::IDX_SS, 8'hff, 4'h0, r, e);
    rdc("strobe off write", amp_regs_pkg::IDX_SS, 8'h5a);
    apb(1'b1, 10'h06c, 8'hff, 4'hf, r, e);
    check("unmapped write error", {31'h0, e}, 32'h1);
    apb(1'b0, 10'h000, 8'h00, 4'h0, r, e);
    check("unmapped read data", r, 32'h0);
    check("unmapped read error", {31'h0, e}, 32'h1);
    $display("test access kinds done");
    foreach (ss_vals[i])
    begin
      d = ss_vals[i];
      wr(amp_regs_pkg::IDX_SS, d);
      @(posedge pclk);
      check("spread cfg", {28'h0, ss_cfg}, {28'h0, d[4], d[5] & d[4], d[1], d[0]});
    end
    $display("test spread enables done");
    for (int p = 0; p < 5; p++)
    begin
      power_state_code <= 8'(p);
      repeat (3) @(posedge pclk);
      rdc("power state", amp_regs_pkg::IDX_POWER, 8'(p));
    end
    for (int m = 0; m < 4; m++)
    begin
      right_silenced_flag <= m[1];
      left_silenced_flag  <= m[0];
      repeat (3) @(posedge pclk);
      rdc("mute status", amp_regs_pkg::IDX_MUTE, {6'h0, m[1:0]});
    end
    $display("test status registers done");
    power_state_code <= 8'h00;
    for (int s = 0; s < 4; s++)
    begin
      d = {4'h0, 2'(s), 2'(3 - s)};
      wr(amp_regs_pkg::IDX_PHASE, d);
      repeat (3) @(posedge pclk);
      check("phase cfg", {28'h0, phase_cfg}, {28'h0, d[3:0]});
      check("phase degrees", {24'h0, ramp_phase_deg}, 32'(s * 45));
    end
    // phase written during play waits until play ends
    power_state_code <= 8'h03;
    repeat (3) @(posedge pclk);
    wr(amp_regs_pkg::IDX_PHASE, 8'h04);
    repeat (3) @(posedge pclk);
    check("phase frozen in play", {24'h0, ramp_phase_deg}, 32'd135);
    power_state_code <= 8'h00;
    repeat (3) @(posedge pclk);
    check("phase after play", {24'h0, ramp_phase_deg}, 32'd45);
    $display("test phase selection done");
    foreach (flips[f])
    begin
      wr(amp_regs_pkg::IDX_FLIP, {5'h0, flips[f]});
      for (int m = 1; m < 4; m++)
      begin
        right_silenced_flag <= m[1];
        left_silenced_flag  <= m[0];
        pin_user_value      <= 3'h5 ^ m[2:0];
        for (int c = 0; c < 7; c++)
        begin
          pin_select <= {3{4'(c)}};
          repeat (4) @(posedge pclk);
          check("pin drive", {29'h0, pin_drive}, {29'h0, pin_exp(4'(c), 3'h5 ^ m[2:0], m[0], m[1], flips[f])});
        end
      end
    end
    $display("test pin sources done");
    wr(amp_regs_pkg::IDX_PHASE, 8'h03);
    internal_sync_pulse <= 1'b1;
    @(posedge pclk);
    internal_sync_pulse <= 1'b0;
    count_sync(5, cnt);
    check("internal sync pulse", 32'(cnt), 32'h1);
    wr(amp_regs_pkg::IDX_PHASE, 8'h01);
    sync_pin <= 1'b1;
    count_sync(8, cnt);
    check("pin sync pulse", 32'(cnt), 32'h1);
    sync_pin <= 1'b0;
    wr(amp_regs_pkg::IDX_PHASE, 8'h02);
    internal_sync_pulse <= 1'b1;
    @(posedge pclk);
    internal_sync_pulse <= 1'b0;
    count_sync(5, cnt);
    check("sync disabled", 32'(cnt), 32'h0);
    $display("test sync sources done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
